// *** e1ec_pkg.sv ***
// constants shared by the e1 error counter and channel monitor block
package e1ec_pkg;
	// ****************************************
	// register offsets on the control port
	// ****************************************
	localparam logic [7:0] ADDR_VIOL_HI = 8'h00;
	localparam logic [7:0] ADDR_VIOL_LO = 8'h01;
	localparam logic [7:0] ADDR_CRC_HI = 8'h02;
	localparam logic [7:0] ADDR_CRC_LO = 8'h03;
	localparam logic [7:0] ADDR_EBIT_HI = 8'h04;
	localparam logic [7:0] ADDR_EBIT_LO = 8'h05;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	// ****************************************
	// counter widths, limits and field split
	// ****************************************
	localparam int VIOL_W = 16;
	localparam int CRC_W = 10;
	localparam int EBIT_W = 10;
	localparam int FAS_W = 12;
	localparam int FAS_SPLIT = 6;
	localparam logic [15:0] VIOL_MAX = 16'hffff;
	localparam logic [15:0] CRC_MAX = 16'h03ff;
	localparam logic [15:0] EBIT_MAX = 16'h03ff;
	localparam logic [15:0] FAS_MAX = 16'h0fff;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	// ****************************************
	// line timing and interval lengths
	// ****************************************
	localparam longint LINE_RATE_HZ = 2048000;
	localparam longint LONG_INTERVAL_MS = 1000;
	localparam longint SHORT_INTERVAL_US = 62500;
	localparam int unsigned LONG_BITS = int'(LINE_RATE_HZ * LONG_INTERVAL_MS / 1000);
	localparam int unsigned SHORT_BITS = int'(LINE_RATE_HZ * SHORT_INTERVAL_US / 1000000);
	localparam int TMR_W = 21;
	// ****************************************
	// line code and frame positions
	// ****************************************
	localparam logic [2:0] HDB3_ZERO_RUN = 3'h3;
	localparam logic [3:0] EBIT_FRAME_A = 4'hd;
	localparam logic [3:0] EBIT_FRAME_B = 4'hf;
	localparam logic [2:0] MON_LAST_BIT = 3'h7;
	localparam int CHAN_W = 5;
endpackage : e1ec_pkg

// *** e1ec_pin_sync.sv ***
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module e1ec_pin_sync #(
	parameter int W = 1
) (
	// clock and control
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// pins and filtered levels
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else if (ce_i)
		begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit changes only once stages two and three agree
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			level_o <= '0;
		else if (ce_i)
			level_o <= (s2_q & ~(s2_q ^ s3_q)) | (level_o & (s2_q ^ s3_q));
	end
endmodule : e1ec_pin_sync

// *** e1ec_chan_mon.sv ***
// captures one selected 64 kbps channel into a readable byte
`timescale 1ns/10ps
module e1ec_chan_mon (
	// clock and control
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// serial stream position and data
	input wire logic bit_en_i,
	input wire logic [4:0] chan_i,
	input wire logic [2:0] bit_idx_i,
	input wire logic data_i,
	// channel select and captured byte
	input wire logic [4:0] sel_i,
	output logic [7:0] byte_o
);
	logic [6:0] shift_q;
	logic hit;

	assign hit = bit_en_i && (chan_i == sel_i);

	// first bit of the channel ends up in the msb
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			shift_q <= 7'h00;
			byte_o <= 8'h00;
		end
		else if (ce_i && hit)
		begin
			shift_q <= {shift_q[5:0], data_i};
			if (bit_idx_i == e1ec_pkg::MON_LAST_BIT)
				byte_o <= {shift_q, data_i};
		end
	end
endmodule : e1ec_chan_mon

// *** e1ec_top.sv ***
// e1 error counters with interval latching and channel monitors
// ****************************************
// Functional notes
// - all counters latch together each second, or each 62.5 ms when selected
// - held values stay for the whole next interval; host reads within it
// - every counter stops at its maximum until the interval ends
// - violation count is 16 bits: high byte at 0x00, low at 0x01
// - violation mode zero counts consecutive same-polarity marks
// - in that mode with hdb3 decode on, violations after exactly three zeros are not counted
// - violation mode one counts successive same-polarity bipolar violations
// - violation counter ignores sync loss and saturates at 65535
// - crc4 count is 10 bits: bits 9..8 at 0x02[1:0], low byte 0x03
// - crc4 and e-bit counters stop on fas or crc4 sync loss; e-bit also stops with crc4 multiframe off
// - e-bit counter counts zero e bits in frames 13 and 15
// - e-bit count is 10 bits: bits 9..8 at 0x04[1:0], low byte 0x05
// - fas count 12 bits: 11..6 at 0x02[7:2], 5..0 at 0x04[7:2]
// - fas word errors counted except in receive sync loss or any alignment search
// - one transmit and one receive channel copied into monitor bytes by select
// - monitor byte holds the first channel bit in its msb
// - interval timer counts the recovered receive clock
// ****************************************
`timescale 1ns/10ps
module e1ec_top #(
	parameter int unsigned LONG_BITS = e1ec_pkg::LONG_BITS,
	parameter int unsigned SHORT_BITS = e1ec_pkg::SHORT_BITS
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// receive line pins
	input wire logic rx_line_clk_i,
	input wire logic rx_line_pos_i,
	input wire logic rx_line_neg_i,
	// control bits
	input wire logic interval_select_bit_i,
	input wire logic violation_mode_bit_i,
	input wire logic receive_hdb3_enable_i,
	input wire logic crc4_multiframe_enable_i,
	// framer sync state
	input wire logic fas_sync_lost_i,
	input wire logic crc_sync_lost_i,
	input wire logic receive_sync_lost_i,
	input wire logic fas_search_i,
	input wire logic cas_search_i,
	input wire logic crc_search_i,
	// framer error events
	input wire logic crc_error_i,
	input wire logic fas_word_error_i,
	input wire logic ebit_strobe_i,
	input wire logic [3:0] ebit_frame_i,
	input wire logic ebit_value_i,
	// channel streams
	input wire logic tx_bit_en_i,
	input wire logic [4:0] tx_chan_i,
	input wire logic [2:0] tx_bit_idx_i,
	input wire logic tx_data_i,
	input wire logic rx_bit_en_i,
	input wire logic [4:0] rx_chan_i,
	input wire logic [2:0] rx_bit_idx_i,
	input wire logic rx_data_i,
	input wire logic [4:0] tx_monitor_select_i,
	input wire logic [4:0] rx_monitor_select_i,
	// parallel control port
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	// status and monitor outputs
	output logic interval_timer_flag_o,
	output logic [7:0] tx_channel_monitor_byte_o,
	output logic [7:0] rx_channel_monitor_byte_o
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic [15:0] maxv);
		sat_inc = (v >= maxv) ? v : 16'(v + 16'h0001);
	endfunction : sat_inc

	logic [2:0] line_lvl;
	logic rclk_prev_q;
	logic rx_tick;
	logic bnd;
	logic [e1ec_pkg::TMR_W-1:0] tmr_q;
	logic [e1ec_pkg::TMR_W-1:0] tmr_lim;

	// ****************************************
	// line pin synchronisation
	// ****************************************
	e1ec_pin_sync #(.W(3)) u_sync (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.pin_i({rx_line_clk_i, rx_line_pos_i, rx_line_neg_i}),
		.level_o(line_lvl)
	);

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			rclk_prev_q <= 1'b0;
		else if (ce_i)
			rclk_prev_q <= line_lvl[2];
	end

	assign rx_tick = line_lvl[2] && !rclk_prev_q;

	// ****************************************
	// interval timer
	// ****************************************
	assign tmr_lim = interval_select_bit_i ? e1ec_pkg::TMR_W'(SHORT_BITS - 1) :
		e1ec_pkg::TMR_W'(LONG_BITS - 1);
	assign bnd = rx_tick && (tmr_q >= tmr_lim);

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			tmr_q <= '0;
		else if (ce_i && rx_tick)
			tmr_q <= bnd ? '0 : e1ec_pkg::TMR_W'(tmr_q + 1'b1);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			interval_timer_flag_o <= 1'b0;
		else if (ce_i)
			interval_timer_flag_o <= bnd;
	end

	// ****************************************
	// violation detection
	// ****************************************
	logic mark;
	logic have_mark_q;
	logic last_pol_q;
	logic [2:0] zeros_q;
	logic have_bpv_q;
	logic last_bpv_pol_q;
	logic bpv;
	logic hdb3_code;
	logic viol_inc;

	assign mark = line_lvl[1] || line_lvl[0];
	assign bpv = rx_tick && mark && have_mark_q && (line_lvl[1] == last_pol_q);
	assign hdb3_code = bpv && (zeros_q == e1ec_pkg::HDB3_ZERO_RUN);
	always_comb
	begin
		if (violation_mode_bit_i)
			viol_inc = bpv && have_bpv_q && (line_lvl[1] == last_bpv_pol_q);
		else
			viol_inc = bpv && !(receive_hdb3_enable_i && hdb3_code);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			have_mark_q <= 1'b0;
			last_pol_q <= 1'b0;
			zeros_q <= 3'h0;
		end
		else if (ce_i && rx_tick)
		begin
			if (mark)
			begin
				have_mark_q <= 1'b1;
				last_pol_q <= line_lvl[1];
				zeros_q <= 3'h0;
			end
			else if (zeros_q != 3'h7)
				zeros_q <= 3'(zeros_q + 3'h1);
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			have_bpv_q <= 1'b0;
			last_bpv_pol_q <= 1'b0;
		end
		else if (ce_i && bpv)
		begin
			have_bpv_q <= 1'b1;
			last_bpv_pol_q <= line_lvl[1];
		end
	end

	// ****************************************
	// error event qualification
	// ****************************************
	logic crc_en;
	logic fas_en;
	logic crc_inc;
	logic ebit_inc;
	logic fas_inc;

	assign crc_en = !fas_sync_lost_i && !crc_sync_lost_i;
	assign fas_en = !receive_sync_lost_i && !fas_search_i && !cas_search_i && !crc_search_i;
	assign crc_inc = crc_error_i && crc_en;
	assign ebit_inc = crc_en && crc4_multiframe_enable_i && ebit_strobe_i && !ebit_value_i &&
		((ebit_frame_i == e1ec_pkg::EBIT_FRAME_A) || (ebit_frame_i == e1ec_pkg::EBIT_FRAME_B));
	assign fas_inc = fas_word_error_i && fas_en;

	// ****************************************
	// running counters and holding registers
	// ****************************************
	logic [15:0] viol_cnt_q;
	logic [15:0] viol_hold_q;
	logic [15:0] viol_next;
	logic [9:0] crc_cnt_q;
	logic [9:0] crc_hold_q;
	logic [9:0] crc_next;
	logic [15:0] crc_sat;
	logic [9:0] eb_cnt_q;
	logic [9:0] eb_hold_q;
	logic [9:0] eb_next;
	logic [15:0] eb_sat;
	logic [11:0] fas_cnt_q;
	logic [11:0] fas_hold_q;
	logic [11:0] fas_next;
	logic [15:0] fas_sat;

	assign viol_next = viol_inc ? sat_inc(viol_cnt_q, e1ec_pkg::VIOL_MAX) : viol_cnt_q;
	assign crc_sat = sat_inc(16'(crc_cnt_q), e1ec_pkg::CRC_MAX);
	assign crc_next = crc_inc ? crc_sat[9:0] : crc_cnt_q;
	assign eb_sat = sat_inc(16'(eb_cnt_q), e1ec_pkg::EBIT_MAX);
	assign eb_next = ebit_inc ? eb_sat[9:0] : eb_cnt_q;
	assign fas_sat = sat_inc(16'(fas_cnt_q), e1ec_pkg::FAS_MAX);
	assign fas_next = fas_inc ? fas_sat[11:0] : fas_cnt_q;

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			viol_cnt_q <= e1ec_pkg::COUNT_RST;
			viol_hold_q <= e1ec_pkg::COUNT_RST;
		end
		else if (ce_i)
		begin
			if (bnd)
			begin
				viol_hold_q <= viol_next;
				viol_cnt_q <= e1ec_pkg::COUNT_RST;
			end
			else
				viol_cnt_q <= viol_next;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			crc_cnt_q <= '0;
			crc_hold_q <= '0;
			eb_cnt_q <= '0;
			eb_hold_q <= '0;
		end
		else if (ce_i)
		begin
			if (bnd)
			begin
				crc_hold_q <= crc_next;
				eb_hold_q <= eb_next;
				crc_cnt_q <= '0;
				eb_cnt_q <= '0;
			end
			else
			begin
				crc_cnt_q <= crc_next;
				eb_cnt_q <= eb_next;
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			fas_cnt_q <= '0;
			fas_hold_q <= '0;
		end
		else if (ce_i)
		begin
			if (bnd)
			begin
				fas_hold_q <= fas_next;
				fas_cnt_q <= '0;
			end
			else
				fas_cnt_q <= fas_next;
		end
	end

	// ****************************************
	// control port read decode
	// ****************************************
	logic [7:0] rd_mux;

	// writes are accepted and dropped; holding registers load only at boundaries
	always_comb
	begin
		case (addr_i)
			e1ec_pkg::ADDR_VIOL_HI: rd_mux = viol_hold_q[15:8];
			e1ec_pkg::ADDR_VIOL_LO: rd_mux = viol_hold_q[7:0];
			e1ec_pkg::ADDR_CRC_HI: rd_mux = {fas_hold_q[11:e1ec_pkg::FAS_SPLIT], crc_hold_q[9:8]};
			e1ec_pkg::ADDR_CRC_LO: rd_mux = crc_hold_q[7:0];
			e1ec_pkg::ADDR_EBIT_HI: rd_mux = {fas_hold_q[e1ec_pkg::FAS_SPLIT-1:0], eb_hold_q[9:8]};
			e1ec_pkg::ADDR_EBIT_LO: rd_mux = eb_hold_q[7:0];
			default: rd_mux = e1ec_pkg::UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			rdata_o <= 8'h00;
		else if (ce_i && rd_i)
			rdata_o <= rd_mux;
	end

	// ****************************************
	// channel monitors
	// ****************************************
	e1ec_chan_mon u_tx_mon (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.bit_en_i(tx_bit_en_i),
		.chan_i(tx_chan_i),
		.bit_idx_i(tx_bit_idx_i),
		.data_i(tx_data_i),
		.sel_i(tx_monitor_select_i),
		.byte_o(tx_channel_monitor_byte_o)
	);

	e1ec_chan_mon u_rx_mon (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.bit_en_i(rx_bit_en_i),
		.chan_i(rx_chan_i),
		.bit_idx_i(rx_bit_idx_i),
		.data_i(rx_data_i),
		.sel_i(rx_monitor_select_i),
		.byte_o(rx_channel_monitor_byte_o)
	);

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);

	a_viol_saturate:
	assert property (ce_i && !bnd && viol_cnt_q == e1ec_pkg::VIOL_MAX |=> viol_cnt_q == e1ec_pkg::VIOL_MAX)
		else $error("violation count left its maximum");
	a_fas_saturate:
	assert property (ce_i && !bnd && fas_cnt_q == 12'hfff |=> fas_cnt_q == 12'hfff)
		else $error("fas count wrapped");
	a_bnd_clear:
	assert property (ce_i && bnd |=> viol_cnt_q == 16'h0000 && crc_cnt_q == 10'h000 && fas_cnt_q == 12'h000)
		else $error("counts not cleared at boundary");
	a_hold_capture:
	assert property (ce_i && bnd && !viol_inc && !crc_inc |=>
		viol_hold_q == $past(viol_cnt_q) && crc_hold_q == $past(crc_cnt_q))
		else $error("holding registers missed the boundary");
	a_hold_stable:
	assert property (!(ce_i && bnd) |=>
		$stable(viol_hold_q) && $stable(crc_hold_q) && $stable(eb_hold_q) && $stable(fas_hold_q))
		else $error("holding register changed inside an interval");
	a_crc_inhibit:
	assert property (ce_i && !bnd && (fas_sync_lost_i || crc_sync_lost_i) |=> $stable(crc_cnt_q) && $stable(eb_cnt_q))
		else $error("crc or e-bit counted during sync loss");
	a_fas_inhibit:
	assert property (ce_i && !bnd && (receive_sync_lost_i || fas_search_i) |=> $stable(fas_cnt_q))
		else $error("fas counted while inhibited");
	a_ebit_count:
	assert property (ce_i && !bnd && ebit_inc && eb_cnt_q != 10'h3ff |=> eb_cnt_q == 10'($past(eb_cnt_q) + 10'h001))
		else $error("e-bit count did not step");
	a_hdb3_exclude:
	assert property (ce_i && !bnd && !violation_mode_bit_i && receive_hdb3_enable_i && hdb3_code |=>
		viol_cnt_q == $past(viol_cnt_q))
		else $error("hdb3 substitution counted");
	a_cv_mode:
	assert property (ce_i && !bnd && violation_mode_bit_i && bpv && have_bpv_q && line_lvl[1] == last_bpv_pol_q &&
		viol_cnt_q != e1ec_pkg::VIOL_MAX |=> viol_cnt_q == 16'($past(viol_cnt_q) + 16'h0001))
		else $error("code violation not counted");
	a_read_high:
	assert property (ce_i && rd_i && addr_i == 8'h00 && !bnd |=> rdata_o == viol_hold_q[15:8])
		else $error("violation high byte misread");

	c_boundary: cover property (ce_i && bnd);
	c_viol_sat: cover property (viol_cnt_q == e1ec_pkg::VIOL_MAX);
	c_hdb3_skip: cover property (receive_hdb3_enable_i && hdb3_code);
	c_read_fas: cover property (ce_i && rd_i && addr_i == 8'h04 ##1 rdata_o != 8'h00);
endmodule : e1ec_top

// *** e1ec_host_model.sv ***
// host processor model driving the parallel control port
`timescale 1ns/10ps
module e1ec_host_model (
	// clock
	input wire logic clk_sys_i,
	// control port
	output logic [7:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i
);
	initial
	begin
		addr_o = 8'h00;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end

	// callers read each held total one or more times within the interval that it stands
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_sys_i);
		rd_o = 1'b0;
		addr_o = ~a;
		@(negedge clk_sys_i);
		d = rdata_i;
	endtask : read

	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_sys_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : write
endmodule : e1ec_host_model

// *** e1ec_top_test.sv ***
// self-checking bench for the e1 error counter block
`timescale 1ns/10ps
module e1ec_top_test;
	localparam int LB = 80;
	localparam int SB = 8;
	logic clk_sys_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, lclk = 1'b0, lpos = 1'b0, lneg = 1'b0;
	logic isel = 1'b0, vmode = 1'b0, hdb3 = 1'b0, mfen = 1'b1, fas_lost = 1'b0, crc_lost = 1'b0;
	logic rx_lost = 1'b0, fas_srch = 1'b0, cas_srch = 1'b0, crc_srch = 1'b0, crc_err = 1'b0, fas_err = 1'b0;
	logic eb_stb = 1'b0, eb_val = 1'b0, tx_en = 1'b0, rx_en = 1'b0, tx_d = 1'b0, rx_d = 1'b0, rd, wr, flag;
	logic seen = 1'b0;
	logic [3:0] eb_frm = 4'h0;
	logic [2:0] bidx = 3'h0;
	// channel 6 transmit, channel 15 receive
	logic [4:0] tx_ch = 5'h00, rx_ch = 5'h00, tx_sel = 5'h06, rx_sel = 5'h0f;
	logic [7:0] addr, wdata, rdata, tx_mon, rx_mon, rv;
	int mismatches = 0, checked = 0, bits = 0, last_bits = 0, gap = 0;

	e1ec_top #(.LONG_BITS(LB), .SHORT_BITS(SB)) uut (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i),
		.rx_line_clk_i(lclk), .rx_line_pos_i(lpos), .rx_line_neg_i(lneg),
		.interval_select_bit_i(isel), .violation_mode_bit_i(vmode),
		.receive_hdb3_enable_i(hdb3), .crc4_multiframe_enable_i(mfen),
		.fas_sync_lost_i(fas_lost), .crc_sync_lost_i(crc_lost), .receive_sync_lost_i(rx_lost),
		.fas_search_i(fas_srch), .cas_search_i(cas_srch), .crc_search_i(crc_srch),
		.crc_error_i(crc_err), .fas_word_error_i(fas_err),
		.ebit_strobe_i(eb_stb), .ebit_frame_i(eb_frm), .ebit_value_i(eb_val),
		.tx_bit_en_i(tx_en), .tx_chan_i(tx_ch), .tx_bit_idx_i(bidx), .tx_data_i(tx_d),
		.rx_bit_en_i(rx_en), .rx_chan_i(rx_ch), .rx_bit_idx_i(bidx), .rx_data_i(rx_d),
		.tx_monitor_select_i(tx_sel), .rx_monitor_select_i(rx_sel),
		.addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata),
		.interval_timer_flag_o(flag), .tx_channel_monitor_byte_o(tx_mon), .rx_channel_monitor_byte_o(rx_mon)
	);

	e1ec_host_model host (
		.clk_sys_i(clk_sys_i), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .rdata_i(rdata)
	);

	always #5 clk_sys_i = ~clk_sys_i;

	// line bits between interval flags
	always @(posedge clk_sys_i)
	begin
		if (flag === 1'b1)
		begin
			seen = 1'b1;
			gap = bits - last_bits;
			last_bits = bits;
		end
	end

	// ****************************************
	// checking and closing
	// ****************************************
	task automatic check(input string what, input logic [7:0] seen_v, input logic [7:0] exp_v);
		checked++;
		if (seen_v !== exp_v)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp_v, seen_v);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// ****************************************
	// stimulus tasks
	// ****************************************
	task automatic line_bit(input logic p, input logic n);
		@(negedge clk_sys_i);
		lpos = p;
		lneg = n;
		repeat (7) @(negedge clk_sys_i);
		lclk = 1'b1;
		bits++;
		repeat (8) @(negedge clk_sys_i);
		lclk = 1'b0;
	endtask : line_bit

	// runs positive marks until a boundary has passed
	task automatic align;
		seen = 1'b0;
		for (int k = 0; k < 2 * LB && seen !== 1'b1; k++)
			line_bit(1'b1, 1'b0);
		if (seen !== 1'b1)
		begin
			mismatches++;
			report_and_stop();
		end
	endtask : align

	// one whole interval of line bits with framer events alongside
	task automatic run_interval(input string pat, input int nb, input int nc, input int nf, input int ne);
		seen = 1'b0;
		fork
			for (int i = 0; i < nb; i++)
				line_bit(pat[i] == "+", pat[i] == "-");
			begin
				for (int i = 0; i < ne + 2 || i < nc || i < nf; i++)
				begin
					@(negedge clk_sys_i);
					crc_err = (i < nc);
					fas_err = (i < nf);
					eb_stb = (i < ne + 2);
					eb_val = (i == 1);
					eb_frm = (i == 0) ? 4'he : (i % 2 == 1) ? e1ec_pkg::EBIT_FRAME_A : e1ec_pkg::EBIT_FRAME_B;
				end
				@(negedge clk_sys_i);
				crc_err = 1'b0;
				fas_err = 1'b0;
				eb_stb = 1'b0;
			end
		join
		check("flag", {7'h00, seen}, 8'h01);
	endtask : run_interval

	task automatic counts(input logic [15:0] v, input logic [9:0] c, input logic [9:0] e, input logic [11:0] f);
		logic [7:0] d;
		host.read(e1ec_pkg::ADDR_VIOL_HI, d);
		check("viol_hi", d, v[15:8]);
		host.read(e1ec_pkg::ADDR_VIOL_LO, d);
		check("viol_lo", d, v[7:0]);
		host.read(e1ec_pkg::ADDR_CRC_HI, d);
		check("crc_hi", d, {f[11:6], c[9:8]});
		host.read(e1ec_pkg::ADDR_CRC_LO, d);
		check("crc_lo", d, c[7:0]);
		host.read(e1ec_pkg::ADDR_EBIT_HI, d);
		check("ebit_hi", d, {f[5:0], e[9:8]});
		host.read(e1ec_pkg::ADDR_EBIT_LO, d);
		check("ebit_lo", d, e[7:0]);
	endtask : counts

	task automatic chan(input logic [4:0] tc, input logic [7:0] tb, input logic [4:0] rc, input logic [7:0] rb);
		for (int i = 0; i < 8; i++)
		begin
			@(negedge clk_sys_i);
			tx_en = 1'b1;
			rx_en = 1'b1;
			tx_ch = tc;
			rx_ch = rc;
			bidx = 3'(i);
			tx_d = tb[7 - i];
			rx_d = rb[7 - i];
		end
		@(negedge clk_sys_i);
		tx_en = 1'b0;
		rx_en = 1'b0;
		repeat (2) @(negedge clk_sys_i);
	endtask : chan

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (8) @(negedge clk_sys_i);
		srst_i = 1'b0;
		chan(5'h06, 8'hc1, 5'h0f, 8'h35);
		check("tx_mon", tx_mon, 8'hc1);
		check("rx_mon", rx_mon, 8'h35);
		chan(5'h07, 8'h5a, 5'h0e, 8'hc3);
		check("tx_keep", tx_mon, 8'hc1);
		check("rx_keep", rx_mon, 8'h35);
		$display("test monitor done");
		align();
		fas_lost = 1'b1;
		rx_lost = 1'b1;
		run_interval("-+++--", LB, 5, 5, 4);
		counts(16'h0003, 10'h000, 10'h000, 12'h000);
		$display("test sync loss done");
		fas_lost = 1'b0;
		rx_lost = 1'b0;
		hdb3 = 1'b1;
		run_interval("+000++", LB, 5, 3, 2);
		counts(16'h0001, 10'h005, 10'h002, 12'h003);
		check("gap_long", gap[7:0], 8'(LB));
		for (int a = 0; a < 6; a++)
			host.write(8'(a), 8'hff);
		counts(16'h0001, 10'h005, 10'h002, 12'h003);
		host.read(8'h06, rv);
		check("unmapped", rv, e1ec_pkg::UNMAPPED_DATA);
		$display("test counting done");
		vmode = 1'b1;
		cas_srch = 1'b1;
		run_interval("+--+++", LB, 4, 2, 1);
		counts(16'h0002, 10'h004, 10'h001, 12'h000);
		$display("test code violations done");
		cas_srch = 1'b0;
		run_interval("", LB, 1030, 0, 1030);
		counts(16'h0000, 10'h3ff, 10'h3ff, 12'h000);
		$display("test saturation done");
		isel = 1'b1;
		crc_lost = 1'b1;
		fas_srch = 1'b1;
		align();
		run_interval("", SB, 3, 2, 2);
		counts(16'h0000, 10'h000, 10'h000, 12'h000);
		check("gap_short", gap[7:0], 8'(SB));
		$display("test short interval done");
		crc_lost = 1'b0;
		fas_srch = 1'b0;
		crc_srch = 1'b1;
		mfen = 1'b0;
		run_interval("", SB, 3, 2, 2);
		counts(16'h0000, 10'h003, 10'h000, 12'h000);
		$display("test multiframe off done");
		report_and_stop();
	end
endmodule : e1ec_top_test
